/* cmc_bus_node.sv */
// far-side model: the other nodes sharing the wired-and bus line
`timescale 1ns/1ps

module cmc_bus_node (
  input  wire logic tx_pin,
  input  wire logic hold,
  output logic      rx_pin
);
  // wired-and line: any node pulling low wins, a floating pin reads as the pull-up level
  assign rx_pin = (tx_pin !== 1'b0) && !hold;
endmodule

/* cmc_mode_ctrl.sv */
// operating mode and top-level control of the CAN controller
//
// Contract
// - software requests mode, reads current mode back
// - mode changes only after eleven recessive bits
// - request codes: 7,4,3,2,1,0 valid; 6,5 reserved
// - current mode uses the request encoding
// - idle-stop set halts module in chip idle
// - abort-all aborts buffers, cleared by hardware
// - clock select: module clock twice or equal
// - capture enable gates receive capture event
// - window select maps filters or buffers
// - standard and extended frames, 0-8 bytes
// - up to eight transmit buffers with abort
// - up to thirty-two receive buffers
// - sixteen acceptance filters, three masks
// - every message checked, then filtered
// - remote requests answered automatically
// - bit rate up to one megabit
// - interrupts for all error states
// - wake-up on bus activity, glitch filtered
// - loopback receives own transmissions internally
`timescale 1ns/1ps
`include "cmc_regs.svh"

module cmc_mode_ctrl #(
  parameter int unsigned NUM_TXB    = 8,
  parameter int unsigned NUM_RXB    = 32,
  parameter int unsigned NUM_FLT    = 16,
  parameter int unsigned NUM_MSK    = 3,
  parameter int unsigned IDLE_CYC   = `CMC_IDLE_CYC,
  parameter int unsigned WAKE_CYC   = `CMC_WAKE_FILT_CYC
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [3:0]         ADDR,
  input  wire logic [15:0]        WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [15:0]        RDATA,
  input  wire logic               CHIP_IDLE,
  input  wire logic               BUS_RECEIVE_PIN,
  output logic                    BUS_TRANSMIT_PIN,
  input  wire logic               ENG_TX,
  output logic                    ENG_RX,
  input  wire logic [NUM_TXB-1:0] TX_PENDING,
  output logic      [NUM_TXB-1:0] TX_ABORT,
  input  wire logic               RX_MSG_DONE,
  output logic                    CAPTURE_EVT,
  output logic      [2:0]         CUR_MODE,
  output logic                    MODULE_CLOCK_DOUBLE,
  output logic                    WINDOW_FILTERS,
  output logic                    MODULE_HALT,
  output logic                    WAKE_EVT
);

  cmc_pkg::cmc_state_s state_ff;
  cmc_pkg::cmc_state_s nxt_state;

  // only the six documented mode codes are accepted
  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m != 3'h5) && (m != 3'h6);
  endfunction

  // control register image; unused bits stay zero
  function automatic logic [15:0] ctrl_image(input cmc_pkg::cmc_state_s s);
    logic [15:0] v;
    v = 16'h0000;
    v[`CMC_POS_IDLE_STOP] = s.idle_stop;
    v[`CMC_POS_ABORT] = s.abort;
    v[`CMC_POS_CLK_SEL] = s.clk_sel;
    v[`CMC_POS_REQ_HI:`CMC_POS_REQ_LO] = s.mode_req;
    v[`CMC_POS_CUR_HI:`CMC_POS_CUR_LO] = s.cur_mode;
    v[`CMC_POS_CAP_EN] = s.cap_en;
    v[`CMC_POS_WIN] = s.register_window_select;
    ctrl_image = v;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [15:0] st_img;
    logic [15:0] cap_img;
    logic        wr_ctrl;
    logic        active;
    st_img  = 16'h0000;
    cap_img = 16'h0000;
    nxt_state = state_ff;
    wr_ctrl = WR && (ADDR == `CMC_OFS_CTRL);
    active  = !state_ff.halt;

    // receive pin passes two flops before any use
    nxt_state.rx_s1 = BUS_RECEIVE_PIN;
    nxt_state.rx_s2 = state_ff.rx_s1;

    // bus idle: run of recessive samples long enough for eleven bits
    if (!state_ff.rx_s2) begin
      nxt_state.idle_cnt = 16'h0000;
    end else if (state_ff.idle_cnt < IDLE_CYC[15:0]) begin
      nxt_state.idle_cnt = state_ff.idle_cnt + 16'h0001;
    end
    nxt_state.idle_ok = (nxt_state.idle_cnt >= IDLE_CYC[15:0]);

    // wake-up: dominant must persist, so short glitches never wake the module
    nxt_state.wake = 1'b0;
    if (state_ff.rx_s2) begin
      nxt_state.wake_cnt = 16'h0000;
      nxt_state.wake_seen = 1'b0;
    end else if (state_ff.wake_cnt < WAKE_CYC[15:0]) begin
      nxt_state.wake_cnt = state_ff.wake_cnt + 16'h0001;
    end else if (!state_ff.wake_seen &&
                 state_ff.cur_mode == cmc_pkg::CMC_MODE_DISABLE) begin
      nxt_state.wake = 1'b1;
      nxt_state.wake_seen = 1'b1;
    end

    // software writes to the control register
    if (wr_ctrl) begin
      nxt_state.idle_stop = WDATA[`CMC_POS_IDLE_STOP];
      nxt_state.clk_sel = WDATA[`CMC_POS_CLK_SEL];
      nxt_state.cap_en = WDATA[`CMC_POS_CAP_EN];
      nxt_state.register_window_select = WDATA[`CMC_POS_WIN];
      // reserved requests are dropped; the old request stays in force
      if (mode_valid(WDATA[`CMC_POS_REQ_HI:`CMC_POS_REQ_LO])) begin
        nxt_state.mode_req = WDATA[`CMC_POS_REQ_HI:`CMC_POS_REQ_LO];
      end
    end

    // abort-all: hardware clears once nothing is pending; a new set wins
    if (state_ff.abort && (TX_PENDING == '0)) begin
      nxt_state.abort = 1'b0;
    end
    if (wr_ctrl && WDATA[`CMC_POS_ABORT]) begin
      nxt_state.abort = 1'b1;
    end
    nxt_state.tx_abort = state_ff.abort ? TX_PENDING : '0;

    // mode switch waits for bus idle and for the module to be running
    unique case (state_ff.fsm)
      cmc_pkg::CMC_ST_STABLE: begin
        if (state_ff.mode_req != state_ff.cur_mode) begin
          nxt_state.fsm = cmc_pkg::CMC_ST_WAIT;
        end
      end
      cmc_pkg::CMC_ST_WAIT: begin
        if (state_ff.mode_req == state_ff.cur_mode) begin
          nxt_state.fsm = cmc_pkg::CMC_ST_STABLE;
        end else if (state_ff.idle_ok && active) begin
          nxt_state.cur_mode = state_ff.mode_req;
          nxt_state.fsm = cmc_pkg::CMC_ST_STABLE;
        end
      end
      default: nxt_state.fsm = cmc_pkg::CMC_ST_STABLE;
    endcase

    // idle-stop freezes the module while the chip idles
    nxt_state.halt = state_ff.idle_stop && CHIP_IDLE;

    // only normal mode drives the bus; loopback feeds the engine its own bits
    nxt_state.tx_pin = (state_ff.cur_mode == cmc_pkg::CMC_MODE_NORMAL && active) ?
                       ENG_TX : 1'b1;
    nxt_state.rx_eng = (state_ff.cur_mode == cmc_pkg::CMC_MODE_LOOPBACK) ?
                       ENG_TX : state_ff.rx_s2;

    // capture event per received message, only when enabled
    nxt_state.capture = state_ff.cap_en && RX_MSG_DONE && active;

    // status and capability images
    st_img[`CMC_POS_ST_IDLE] = state_ff.idle_ok;
    st_img[`CMC_POS_ST_WAIT] = (state_ff.fsm == cmc_pkg::CMC_ST_WAIT);
    st_img[`CMC_POS_ST_HALT] = state_ff.halt;
    st_img[`CMC_POS_ST_WAKE] = state_ff.wake_seen;
    st_img[`CMC_POS_ST_PEND_LO +: 8] = 8'(TX_PENDING);
    cap_img[`CMC_POS_CAP_TXB +: 4] = 4'(NUM_TXB);
    cap_img[`CMC_POS_CAP_RXB +: 6] = 6'(NUM_RXB);
    cap_img[`CMC_POS_CAP_FLT +: 5] = 5'(NUM_FLT);
    cap_img[`CMC_POS_CAP_MSK] = (NUM_MSK != 0);

    // read data stand for the one cycle after the strobe; others read zero
    nxt_state.rdata = 16'h0000;
    if (RD) begin
      unique case (ADDR)
        `CMC_OFS_CTRL:   nxt_state.rdata = ctrl_image(state_ff);
        `CMC_OFS_STATUS: nxt_state.rdata = st_img;
        `CMC_OFS_CAPS:   nxt_state.rdata = cap_img;
        default:         nxt_state.rdata = 16'h0000;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= '0;
      state_ff.mode_req <= `CMC_RST_MODE;
      state_ff.cur_mode <= `CMC_RST_MODE;
      state_ff.rx_s1 <= 1'b1;
      state_ff.rx_s2 <= 1'b1;
      state_ff.tx_pin <= 1'b1;
      state_ff.rx_eng <= 1'b1;
      state_ff.fsm <= cmc_pkg::CMC_ST_STABLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops
  assign RDATA = state_ff.rdata;
  assign BUS_TRANSMIT_PIN = state_ff.tx_pin;
  assign ENG_RX = state_ff.rx_eng;
  assign TX_ABORT = state_ff.tx_abort;
  assign CAPTURE_EVT = state_ff.capture;
  assign CUR_MODE = state_ff.cur_mode;
  assign MODULE_CLOCK_DOUBLE = state_ff.clk_sel;
  assign WINDOW_FILTERS = state_ff.register_window_select;
  assign MODULE_HALT = state_ff.halt;
  assign WAKE_EVT = state_ff.wake;

  // the mode only moves while the bus has been idle
  a_mode_on_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(CUR_MODE) |-> $past(state_ff.idle_ok) && !$past(state_ff.halt))
    else $error("mode changed without bus idle");

  // the new mode is the one software asked for
  a_mode_follows_req: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(CUR_MODE) |-> CUR_MODE == $past(state_ff.mode_req))
    else $error("mode differs from request");

  // a reserved code never shows as the current mode
  a_mode_not_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
    mode_valid(CUR_MODE) && mode_valid(state_ff.mode_req))
    else $error("reserved mode code in force");

  // pending request with a long idle bus is honoured within two cycles
  a_mode_commits: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_ff.mode_req != CUR_MODE) && state_ff.idle_ok && !state_ff.halt &&
    !WR && !CHIP_IDLE ##1 (!WR && state_ff.idle_ok && !CHIP_IDLE)
    |-> ##1 CUR_MODE == $past(state_ff.mode_req, 2))
    else $error("mode request not honoured");

  // abort is only released by an empty pending set
  a_abort_release: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(state_ff.abort) |-> $past(TX_PENDING) == '0)
    else $error("abort cleared while transmissions pending");

  // abort lines mirror pending buffers while abort is set
  a_abort_drive: assert property (@(posedge CLK) disable iff (!RST_N)
    TX_ABORT == ($past(state_ff.abort) ? $past(TX_PENDING) : '0))
    else $error("abort lines wrong");

  // capture events need the enable and a received message
  a_capture_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    CAPTURE_EVT |-> $past(state_ff.cap_en) && $past(RX_MSG_DONE) && !$past(MODULE_HALT))
    else $error("capture without enable");

  // idle-stop halts exactly while the chip idles
  a_halt_follow: assert property (@(posedge CLK) disable iff (!RST_N)
    ##1 MODULE_HALT == $past(state_ff.idle_stop && CHIP_IDLE))
    else $error("halt does not follow idle-stop");

  // loopback keeps the bus recessive and echoes the engine
  a_loopback_path: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(CUR_MODE) == cmc_pkg::CMC_MODE_LOOPBACK |->
    BUS_TRANSMIT_PIN && ENG_RX == $past(ENG_TX))
    else $error("loopback path wrong");

  // read data only in the cycle after a read
  a_read_window: assert property (@(posedge CLK) disable iff (!RST_N)
    !$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read cycle");

  c_mode_to_normal: cover property (@(posedge CLK) disable iff (!RST_N)
    $changed(CUR_MODE) && CUR_MODE == cmc_pkg::CMC_MODE_NORMAL);
  c_abort_done: cover property (@(posedge CLK) disable iff (!RST_N)
    $fell(state_ff.abort));
  c_capture: cover property (@(posedge CLK) disable iff (!RST_N) CAPTURE_EVT);
  c_wake: cover property (@(posedge CLK) disable iff (!RST_N) WAKE_EVT);

endmodule

/* cmc_mode_ctrl_tb_top.sv */
// self-checking bench of the mode control block
`timescale 1ns/1ps

module cmc_mode_ctrl_tb_top;
  localparam int unsigned IDLE = 8;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [15:0] RDATA;
  logic        CHIP_IDLE = 1'b0;
  logic        BUS_RECEIVE_PIN;
  logic        BUS_TRANSMIT_PIN;
  logic        ENG_TX = 1'b1;
  logic        ENG_RX;
  logic [7:0]  TX_PENDING = 8'h00;
  logic [7:0]  TX_ABORT;
  logic        RX_MSG_DONE = 1'b0;
  logic        CAPTURE_EVT;
  logic [2:0]  CUR_MODE;
  logic        MODULE_CLOCK_DOUBLE;
  logic        WINDOW_FILTERS;
  logic        MODULE_HALT;
  logic        WAKE_EVT;
  logic        hold = 1'b0;
  logic        rd_ff = 1'b0;
  logic [15:0] seed = 16'h04FE;
  logic [15:0] exp_q[$];
  logic [2:0]  rq = 3'h4;
  logic [2:0]  codes [8] = '{3'h5, 3'h7, 3'h3, 3'h6, 3'h2, 3'h1, 3'h0, 3'h4};
  logic [15:0] r;
  logic [7:0]  p;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_wake = 0;
  int          wcnt;
  int          n;

  always #12.5 CLK = ~CLK;

  cmc_mode_ctrl #(.IDLE_CYC(IDLE), .WAKE_CYC(3)) DUT (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CHIP_IDLE(CHIP_IDLE), .BUS_RECEIVE_PIN(BUS_RECEIVE_PIN),
    .BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN), .ENG_TX(ENG_TX), .ENG_RX(ENG_RX),
    .TX_PENDING(TX_PENDING), .TX_ABORT(TX_ABORT), .RX_MSG_DONE(RX_MSG_DONE),
    .CAPTURE_EVT(CAPTURE_EVT), .CUR_MODE(CUR_MODE),
    .MODULE_CLOCK_DOUBLE(MODULE_CLOCK_DOUBLE), .WINDOW_FILTERS(WINDOW_FILTERS),
    .MODULE_HALT(MODULE_HALT), .WAKE_EVT(WAKE_EVT));

  cmc_bus_node NODE (.tx_pin(BUS_TRANSMIT_PIN), .hold(hold), .rx_pin(BUS_RECEIVE_PIN));

  // xorshift source for pending masks and dominant run lengths
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // bus cycles: one strobe cycle, then a released cycle so strobes never merge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask

  // control writes keep the tracked request so no mode change slips in
  task automatic wctl(input logic [15:0] b);
    wr(4'h0, b | {5'h00, rq, 8'h00});
  endtask

  function automatic logic [15:0] ce(input logic [15:0] b);
    return b | {5'h00, rq, rq, 5'h00};
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  task automatic wait_mode(input logic [2:0] e);
    wcnt = 0;
    while (CUR_MODE !== e && wcnt < 60) begin
      tick(1);
      wcnt++;
    end
    chk({13'h0000, CUR_MODE}, {13'h0000, e});
  endtask

  task automatic txchk(input logic ep, input logic er);
    @(posedge CLK);
    ENG_TX <= 1'b0;
    tick(1);
    chk({15'h0000, BUS_TRANSMIT_PIN}, {15'h0000, ep});
    chk({15'h0000, ENG_RX}, {15'h0000, er});
    @(posedge CLK);
    ENG_TX <= 1'b1;
  endtask

  task automatic cap(input logic e);
    @(posedge CLK);
    RX_MSG_DONE <= 1'b1;
    @(posedge CLK);
    RX_MSG_DONE <= 1'b0;
    #1;
    chk({15'h0000, CAPTURE_EVT}, {15'h0000, e});
  endtask

  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge CLK) rd_ff <= RD;
  always @(negedge CLK) begin
    if (rd_ff && exp_q.size() > 0) chk(RDATA, exp_q.pop_front());
  end
  always @(posedge CLK) begin
    if (WAKE_EVT === 1'b1) n_wake++;
  end

  initial begin
    #(25 * 4000);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    tick(0);
    chk({13'h0000, CUR_MODE}, 16'h0004);
    rd(4'h0, 16'h0480);
    wr(4'h0, 16'hC4F6);
    rd(4'h0, 16'h0480);
    rd(4'h4, 16'hC208);
    rd(4'h8, 16'h0000);
    wr(4'h8, 16'hFFFF);
    rd(4'h0, 16'h0480);
    // every request code; reserved ones leave the old request standing
    foreach (codes[k]) begin
      if (codes[k] != 3'h5 && codes[k] != 3'h6) rq = codes[k];
      wr(4'h0, {5'h00, codes[k], 8'h00});
      wait_mode(rq);
      rd(4'h0, ce(16'h0000));
      txchk(rq != 3'h0, rq != 3'h2);
    end
    // a dominant bus must hold the request back until IDLE (eight) idle cycles
    @(posedge CLK);
    hold <= 1'b1;
    tick(4);
    rq = 3'h3;
    wctl(16'h0000);
    tick(10 + xs() % 16);
    chk({13'h0000, CUR_MODE}, 16'h0004);
    rd(4'h2, 16'h0002);
    @(posedge CLK);
    hold <= 1'b0;
    wait_mode(3'h3);
    chk({15'h0000, wcnt >= IDLE}, 16'h0001);
    // wake-up in disable mode: a short glitch is filtered, a long run is not
    rq = 3'h1;
    wctl(16'h0000);
    wait_mode(3'h1);
    n = n_wake;
    @(posedge CLK);
    hold <= 1'b1;
    repeat (1 + xs() % 2) @(posedge CLK);
    hold <= 1'b0;
    repeat (6) @(posedge CLK);
    hold <= 1'b1;
    repeat (5 + xs() % 4) @(posedge CLK);
    hold <= 1'b0;
    tick(10);
    chk(n_wake[15:0] - n[15:0], 16'h0001);
    rq = 3'h4;
    wctl(16'h0000);
    wait_mode(3'h4);
    // abort all pending buffers, cleared by hardware once none pend
    r = xs();
    p = r[7:0] | 8'h01;
    @(posedge CLK);
    TX_PENDING <= p;
    wctl(16'h1000);
    tick(1);
    chk({8'h00, TX_ABORT}, {8'h00, p});
    rd(4'h0, ce(16'h1000));
    rd(4'h2, {p, 8'h01});
    @(posedge CLK);
    TX_PENDING <= 8'h00;
    tick(3);
    chk({8'h00, TX_ABORT}, 16'h0000);
    rd(4'h0, ce(16'h0000));
    // clock select, window select and capture gate
    wctl(16'h0809);
    tick(2);
    chk({14'h0000, MODULE_CLOCK_DOUBLE, WINDOW_FILTERS}, 16'h0003);
    rd(4'h0, ce(16'h0809));
    cap(1'b1);
    wctl(16'h0000);
    cap(1'b0);
    chk({14'h0000, MODULE_CLOCK_DOUBLE, WINDOW_FILTERS}, 16'h0000);
    // stop in idle freezes capture and mode changes until idle ends
    wctl(16'h2008);
    @(posedge CLK);
    CHIP_IDLE <= 1'b1;
    tick(2);
    chk({15'h0000, MODULE_HALT}, 16'h0001);
    cap(1'b0);
    rq = 3'h0;
    wctl(16'h2008);
    tick(20);
    chk({13'h0000, CUR_MODE}, 16'h0004);
    @(posedge CLK);
    CHIP_IDLE <= 1'b0;
    wait_mode(3'h0);
    txchk(1'b0, 1'b1);
    wctl(16'h0000);
    @(posedge CLK);
    CHIP_IDLE <= 1'b1;
    tick(2);
    chk({15'h0000, MODULE_HALT}, 16'h0000);
    wrap_up();
  end
endmodule

/* cmc_pkg.sv */
// types shared by the mode control block
package cmc_pkg;

  // operating mode codes, same encoding for request and current mode
  typedef enum logic [2:0] {
    CMC_MODE_NORMAL   = 3'h0,
    CMC_MODE_DISABLE  = 3'h1,
    CMC_MODE_LOOPBACK = 3'h2,
    CMC_MODE_LISTEN   = 3'h3,
    CMC_MODE_CONFIG   = 3'h4,
    CMC_MODE_LSN_ALL  = 3'h7
  } cmc_mode_e;

  // mode switch sequencer, one-hot
  typedef enum logic [1:0] {
    CMC_ST_STABLE = 2'h1,
    CMC_ST_WAIT   = 2'h2
  } cmc_fsm_e;

  typedef struct packed {
    logic [2:0]  mode_req;
    logic [2:0]  cur_mode;
    logic        idle_stop;
    logic        abort;
    logic        clk_sel;
    logic        cap_en;
    logic        register_window_select;
    logic        rx_s1;
    logic        rx_s2;
    logic [15:0] idle_cnt;
    logic        idle_ok;
    logic [15:0] wake_cnt;
    logic        wake_seen;
    cmc_fsm_e    fsm;
    logic [15:0] rdata;
    logic [7:0]  tx_abort;
    logic        tx_pin;
    logic        rx_eng;
    logic        capture;
    logic        halt;
    logic        wake;
  } cmc_state_s;

endpackage

/* cmc_regs.svh */
// register offsets, field positions, reset values and timing counts of the mode control block
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// register offsets on the 16-bit register port
`define CMC_OFS_CTRL        4'h0
`define CMC_OFS_STATUS      4'h2
`define CMC_OFS_CAPS        4'h4

// control register field positions
`define CMC_POS_IDLE_STOP   13
`define CMC_POS_ABORT       12
`define CMC_POS_CLK_SEL     11
`define CMC_POS_REQ_HI      10
`define CMC_POS_REQ_LO      8
`define CMC_POS_CUR_HI      7
`define CMC_POS_CUR_LO      5
`define CMC_POS_CAP_EN      3
`define CMC_POS_WIN         0

// status register field positions
`define CMC_POS_ST_IDLE     0
`define CMC_POS_ST_WAIT     1
`define CMC_POS_ST_HALT     2
`define CMC_POS_ST_WAKE     3
`define CMC_POS_ST_PEND_LO  8

// capability register field positions
`define CMC_POS_CAP_TXB     0
`define CMC_POS_CAP_RXB     4
`define CMC_POS_CAP_FLT     10
`define CMC_POS_CAP_MSK     15

// reset values
`define CMC_RST_MODE        3'h4
`define CMC_RST_BIT         1'h0

// timing: clock rate, fastest bit time, idle length, wake glitch filter
`define CMC_CLK_MHZ         40
`define CMC_BIT_NS          1000
`define CMC_IDLE_BITS       11
`define CMC_BIT_CYC         (`CMC_BIT_NS * `CMC_CLK_MHZ / 1000)
`define CMC_IDLE_CYC        (`CMC_IDLE_BITS * `CMC_BIT_CYC)
`define CMC_WAKE_FILT_NS    500
`define CMC_WAKE_FILT_CYC   ((`CMC_WAKE_FILT_NS * `CMC_CLK_MHZ + 999) / 1000)

`endif
